// File: rtl/macrocell_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef MACROCELL_MAP_SVH
`define MACROCELL_MAP_SVH

// register byte offsets; product terms 0..9 sit at 4*n from base
`define OFS_PTERM_BASE 8'h00
`define OFS_CONFIG 8'h28
`define OFS_SPLIT 8'h2C
`define OFS_STATUS 8'h30
`define IDX_PTERM_LAST 6'h09
`define IDX_CONFIG 6'h0A
`define IDX_SPLIT 6'h0B
`define IDX_STATUS 6'h0C

// config register field positions
`define CFG_INVERT 0
`define CFG_TYPE_LO 1
`define CFG_OUTSEL_LO 4
`define CFG_FBSEL_LO 6
`define CFG_TRISTATE 8
`define CFG_STANDBY_EN 9

// register type codes; any other code is the combinatorial path
`define TYPE_D 3'h0
`define TYPE_T 3'h1
`define TYPE_JK 3'h2
`define TYPE_SR 3'h3
`define TYPE_COMB 3'h7

// output and feedback selector codes
`define OUT_REG 2'h2
`define OUT_COMB 2'h3
`define FB_REG 2'h2
`define FB_PIN 2'h3

// erased-state reset values: every control bit connected
`define PTERM_RESET 16'hFFFF
`define CONFIG_RESET 10'h3FF
`define SPLIT_RESET 8'hFF

// timing
`define CLK_PERIOD_NS 10
`define STANDBY_NS 100
`define WAKE_NS 25
`define STANDBY_CYC (`STANDBY_NS / `CLK_PERIOD_NS)
`define WAKE_CYC ((`WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: rtl/macrocell_pkg.sv
// types shared by the macrocell block
package macrocell_pkg;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_STANDBY,
    PWR_WAKING
  } pwr_state_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    axi_rsp_t rsp;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [9:0][15:0] pterm;
    logic [9:0] config_bits;
    logic [7:0] split;
    logic q;
    logic pin_drive;
    logic pin_oe;
    logic [6:0] ded_prev;
    logic pin_prev;
    logic left_prev;
    logic right_prev;
    logic term_clk_prev;
    pwr_state_t pwr;
    logic [3:0] idle;
    logic [1:0] wake_cnt;
  } cell_state_t;

endpackage : macrocell_pkg

// File: rtl/pld_macrocell_config.sv
// one programmable macrocell with its standby controller and axi4-lite regs
//
// Behaviour
// - ten product terms: eight sum, clear, oe/clock
// - both literals false, none ignored, empty true
// - left cells left clock, right cells right
// - invert bit flips every sum into register
// - selectable T, D, JK, SR or combinatorial
// - true clear term zeroes register immediately
// - register cleared at power-up
// - D/T: all eight terms ORed
// - JK/SR: terms split between two ORs
// - output from register, sum, or none
// - feedback from register, pin, or none
// - sum feedback builds wider functions
// - no output plus pin feedback: input
// - enable/clock mode chosen per macrocell
// - mode 0: drive only while term true
// - mode 0: synchronous clock, gated output
// - mode 1: always driven, term clocks register
// - standby after 100 ns quiet, wake on change
// - waking adds 25 ns to pin-output propagation, rounded up to 3 clock cycles (30 ns); register and sum outputs both hold while waking
// - no penalty once already active
// - speed priority programmed: never standby
// - erased cell: comb, active low, pin feedback
// - erased control bits read one
`timescale 1ns/1ns
`include "macrocell_map.svh"

module pld_macrocell_config
  import macrocell_pkg::*;
#(
  parameter bit RIGHT_HALF = 1'b0
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic sync_clock_left_in,
  input wire logic sync_clock_right_in,
  input wire logic [6:0] array_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  input wire axi_req_t axi_req_in,
  output axi_rsp_t axi_rsp_out
);

  localparam logic [3:0] STANDBY_LEN = 4'(`STANDBY_CYC);
  localparam logic [1:0] WAKE_LEN = 2'(`WAKE_CYC);

  cell_state_t s;
  cell_state_t next_s;

  logic chg;
  logic [7:0] sig;
  logic [9:0] pt;
  logic sum_d;
  logic sum_j;
  logic sum_k;
  logic clr;
  logic term_clk;
  logic cap;
  logic [2:0] rtype;
  logic is_comb;

  function automatic logic term_eval(input logic [15:0] conn,
                                     input logic [7:0] x);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (conn[2*i] && !x[i]) begin
        r = 1'b0;
      end
      if (conn[2*i+1] && x[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction : term_eval

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // register read decode; unmapped answers slverr with zero
  function automatic logic [33:0] read_word(input cell_state_t st,
                                            input logic [7:0] addr);
    logic [5:0] idx;
    logic [33:0] r;
    idx = addr[7:2];
    r = {`RESP_OKAY, 32'h00000000};
    if (idx <= `IDX_PTERM_LAST) begin
      r[15:0] = st.pterm[4'(idx)];
    end else if (idx == `IDX_CONFIG) begin
      r[9:0] = st.config_bits;
    end else if (idx == `IDX_SPLIT) begin
      r[7:0] = st.split;
    end else if (idx == `IDX_STATUS) begin
      r[4:0] = {st.pwr == PWR_WAKING, st.pwr == PWR_STANDBY,
                st.pin_oe, st.pin_drive, st.q};
    end else begin
      r[33:32] = `RESP_SLVERR;
    end
    return r;
  endfunction : read_word

  // cell datapath, standby controller and bus slave
  always_comb begin
    logic [31:0] wr;
    logic [5:0] widx;
    logic [1:0] outsel;
    logic [1:0] fbsel;
    logic fb;
    logic inv;
    logic tristate;
    logic sync_now;
    logic sync_prev;
    logic drive_val;
    logic [33:0] rd;
    wr = 32'h00000000;
    widx = s.aw_addr[7:2];
    rd = 34'h0;
    fb = 1'b0;
    drive_val = 1'b0;
    sync_now = 1'b0;
    sync_prev = 1'b0;
    next_s = s;
    rtype = s.config_bits[`CFG_TYPE_LO +: 3];
    outsel = s.config_bits[`CFG_OUTSEL_LO +: 2];
    fbsel = s.config_bits[`CFG_FBSEL_LO +: 2];
    inv = s.config_bits[`CFG_INVERT];
    tristate = s.config_bits[`CFG_TRISTATE];
    is_comb = !(rtype == `TYPE_D || rtype == `TYPE_T ||
                rtype == `TYPE_JK || rtype == `TYPE_SR);

    if (fbsel == `FB_PIN) begin
      fb = pin_in;
    end else if (fbsel == `FB_REG) begin
      fb = s.q;
    end else begin
      fb = 1'b0;
    end
    sig = {fb, array_in};

    for (int i = 0; i < 10; i++) begin
      pt[i] = term_eval(s.pterm[i], sig);
    end
    clr = pt[8];
    term_clk = pt[9];

    sum_d = (|pt[7:0]) ^ inv;
    sum_j = (|(pt[7:0] & s.split)) ^ inv;
    sum_k = (|(pt[7:0] & ~s.split)) ^ inv;

    sync_now = RIGHT_HALF ? sync_clock_right_in : sync_clock_left_in;
    sync_prev = RIGHT_HALF ? s.right_prev : s.left_prev;
    // term clocks register in mode 1
    if (tristate) begin
      cap = sync_now && !sync_prev;
    end else begin
      cap = term_clk && !s.term_clk_prev;
    end
    next_s.left_prev = sync_clock_left_in;
    next_s.right_prev = sync_clock_right_in;
    next_s.term_clk_prev = term_clk;

    if (is_comb) begin
      next_s.q = sum_d;
    end else if (cap) begin
      case (rtype)
        `TYPE_D: next_s.q = sum_d;
        `TYPE_T: next_s.q = s.q ^ sum_d;
        `TYPE_JK: begin
          if (sum_j && sum_k) begin
            next_s.q = !s.q;
          end else if (sum_j || sum_k) begin
            next_s.q = sum_j;
          end
        end
        `TYPE_SR: begin
          if (sum_j != sum_k) begin
            next_s.q = sum_j;
          end
        end
        default: next_s.q = s.q;
      endcase
    end
    if (clr) begin
      next_s.q = 1'b0;
    end

    if (outsel == `OUT_COMB) begin
      drive_val = sum_d;
    end else begin
      drive_val = s.q;
    end

    // input activity for the standby controller
    chg = (array_in != s.ded_prev) || (pin_in != s.pin_prev) ||
          (sync_clock_left_in != s.left_prev) ||
          (sync_clock_right_in != s.right_prev);
    next_s.ded_prev = array_in;
    next_s.pin_prev = pin_in;

    case (s.pwr)
      PWR_ACTIVE: begin
        if (chg) begin
          next_s.idle = 4'h0;
        end else if (s.idle != STANDBY_LEN) begin
          next_s.idle = s.idle + 4'h1;
        end
        // a saturated count still means quiet long enough
        if (s.config_bits[`CFG_STANDBY_EN] && !chg &&
            s.idle >= STANDBY_LEN - 4'h1) begin
          next_s.pwr = PWR_STANDBY;
          next_s.idle = 4'h0;
        end
      end
      PWR_STANDBY: begin
        if (!s.config_bits[`CFG_STANDBY_EN]) begin
          next_s.pwr = PWR_ACTIVE;
        end else if (chg) begin
          next_s.pwr = PWR_WAKING;
          next_s.wake_cnt = WAKE_LEN - 2'h1;
        end
      end
      PWR_WAKING: begin
        if (s.wake_cnt == 2'h0) begin
          next_s.pwr = PWR_ACTIVE;
        end else begin
          next_s.wake_cnt = s.wake_cnt - 2'h1;
        end
      end
      default: next_s.pwr = PWR_ACTIVE;
    endcase

    // pin updates only stall while waking
    if (s.pwr != PWR_WAKING) begin
      next_s.pin_drive = drive_val;
      // mode 0 gated by term; no output is input
      next_s.pin_oe = outsel[1] && (!tristate || term_clk);
    end

    // write channels, static config via registers
    if (s.rsp.awready && axi_req_in.awvalid) begin
      next_s.aw_addr = axi_req_in.awaddr;
      next_s.rsp.awready = 1'b0;
    end
    if (s.rsp.wready && axi_req_in.wvalid) begin
      next_s.w_data = axi_req_in.wdata;
      next_s.w_strb = axi_req_in.wstrb;
      next_s.rsp.wready = 1'b0;
    end
    if (!s.rsp.bvalid && !s.rsp.awready && !s.rsp.wready) begin
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = `RESP_OKAY;
      if (widx <= `IDX_PTERM_LAST) begin
        wr = merge({16'h0000, s.pterm[4'(widx)]}, s.w_data, s.w_strb);
        next_s.pterm[4'(widx)] = wr[15:0];
      end else if (widx == `IDX_CONFIG) begin
        wr = merge({22'h0, s.config_bits}, s.w_data, s.w_strb);
        next_s.config_bits = wr[9:0];
      end else if (widx == `IDX_SPLIT) begin
        wr = merge({24'h000000, s.split}, s.w_data, s.w_strb);
        next_s.split = wr[7:0];
      end else if (widx != `IDX_STATUS) begin
        next_s.rsp.bresp = `RESP_SLVERR;
      end
    end
    if (s.rsp.bvalid && axi_req_in.bready) begin
      next_s.rsp.bvalid = 1'b0;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready = 1'b1;
    end

    // read channel
    if (s.rsp.arready && axi_req_in.arvalid) begin
      rd = read_word(s, axi_req_in.araddr);
      next_s.rsp.rdata = rd[31:0];
      next_s.rsp.rresp = rd[33:32];
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.arready = 1'b0;
    end
    if (s.rsp.rvalid && axi_req_in.rready) begin
      next_s.rsp.rvalid = 1'b0;
      next_s.rsp.arready = 1'b1;
    end
  end

  // state register; erased defaults at reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
      s.pterm <= {10{`PTERM_RESET}};
      s.config_bits <= `CONFIG_RESET;
      s.split <= `SPLIT_RESET;
      s.pwr <= PWR_ACTIVE;
    end else begin
      s <= next_s;
    end
  end

  assign pin_out = s.pin_drive;
  assign pin_oe_out = s.pin_oe;
  assign axi_rsp_out = s.rsp;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_clear_zeroes_reg: assert property (clr |=> !s.q)
    else $error("clear term did not zero register");

  a_d_type_capture: assert property (
    (rtype == `TYPE_D && cap && !clr) |=> s.q == $past(sum_d))
    else $error("d register missed its sum");

  a_t_type_toggle: assert property (
    (rtype == `TYPE_T && cap && !clr && sum_d) |=> s.q != $past(s.q))
    else $error("t register did not toggle");

  a_jk_set_path: assert property (
    (rtype == `TYPE_JK && cap && !clr && sum_j && !sum_k) |=> s.q)
    else $error("jk register did not set");

  a_mode1_always_on: assert property (
    (!s.config_bits[`CFG_TRISTATE] && s.config_bits[`CFG_OUTSEL_LO + 1]
     && s.pwr != PWR_WAKING) |=> pin_oe_out)
    else $error("mode 1 output not driven");

  a_mode0_term_off: assert property (
    (s.config_bits[`CFG_TRISTATE] && !term_clk && s.pwr != PWR_WAKING)
    |=> !pin_oe_out)
    else $error("mode 0 output driven with term false");

  a_standby_entry: assert property (
    (s.pwr == PWR_ACTIVE && s.config_bits[`CFG_STANDBY_EN] && !chg &&
     s.idle >= STANDBY_LEN - 4'h1) |=> s.pwr == PWR_STANDBY)
    else $error("standby not entered after quiet time");

  a_wake_length: assert property (
    (s.pwr == PWR_STANDBY && s.config_bits[`CFG_STANDBY_EN] && chg)
    |=> (s.pwr == PWR_WAKING) [*3] ##1 s.pwr == PWR_ACTIVE)
    else $error("wake penalty length wrong");

  a_turbo_no_standby: assert property (
    !s.config_bits[`CFG_STANDBY_EN] |=> s.pwr != PWR_STANDBY)
    else $error("standby entered with speed bit programmed");

endmodule : pld_macrocell_config

// File: dv/board_model.sv
// board logic on the macrocell's i/o pin: resolves the wire level
`timescale 1ns/1ns

module board_model (
  input wire logic clock_in,
  input wire logic pin_out,
  input wire logic pin_oe_out,
  input wire logic drive_en,
  input wire logic drive_val,
  output logic pin_level
);
  logic last_level = 1'b0;

  // remember the wire so a floating pin can wander
  always_ff @(posedge clock_in) begin
    last_level <= pin_level;
  end

  // cell wins while enabled; an open pin shows no stale value
  // unconnected pin floats
  assign pin_level = pin_oe_out ? pin_out :
                     (drive_en ? drive_val : ~last_level);
endmodule : board_model

// File: dv/pld_macrocell_config_tb.sv
// self-checking testbench for the macrocell block
`timescale 1ns/1ns
`include "macrocell_map.svh"

module pld_macrocell_config_tb;
  import macrocell_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sync_clock_left = 1'b0;
  logic sync_clock_right = 1'b0;
  logic [6:0] array = 7'h00;
  logic drive_val = 1'b0;
  logic pin_level;
  logic pin_out;
  logic pin_oe_out;
  axi_req_t req = '0;
  axi_rsp_t rsp;
  int err_total = 0;
  int num_checks = 0;

  // 100 mhz clock
  always #5 clock_in = ~clock_in;

  pld_macrocell_config #(.RIGHT_HALF(1'b0)) i_dut (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .sync_clock_left_in(sync_clock_left),
    .sync_clock_right_in(sync_clock_right),
    .array_in(array),
    .pin_in(pin_level),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out),
    .axi_req_in(req),
    .axi_rsp_out(rsp)
  );

  board_model i_board (
    .clock_in(clock_in),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out),
    .drive_en(1'b1),
    .drive_val(drive_val),
    .pin_level(pin_level)
  );

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang;
    err_total++;
    $display("MISMATCH t=%0t handshake wait ran out", $time);
    complete_run();
  endtask : hang

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    axi_rsp_t rs;
    int n;
    @(posedge clock_in);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    rs = '0;
    n = 0;
    while (!rs.bvalid) begin
      n++;
      if (n > 50) hang();
      @(negedge clock_in);
      rs = rsp;
      @(posedge clock_in);
      if (rs.awready) req.awvalid <= 1'b0;
      if (rs.wready) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    chk(32'(rs.bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    axi_rsp_t rs;
    int n;
    @(posedge clock_in);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    rs = '0;
    n = 0;
    while (!rs.rvalid) begin
      n++;
      if (n > 50) hang();
      @(negedge clock_in);
      rs = rsp;
      @(posedge clock_in);
      if (rs.arready) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    d = rs.rdata;
    r = rs.rresp;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask : rchk

  // masked status compare
  task automatic st_chk(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(`OFS_STATUS, d, r);
    chk(d & m, e);
  endtask : st_chk

  task automatic pt(input int n, input logic [31:0] v);
    wr(`OFS_PTERM_BASE + 8'(4 * n), v, `RESP_OKAY);
  endtask : pt

  task automatic cfg(input logic [31:0] v);
    wr(`OFS_CONFIG, v, `RESP_OKAY);
  endtask : cfg

  task automatic settle;
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
  endtask : settle

  task automatic pin_chk(input logic [1:0] e);
    settle();
    chk(32'({pin_oe_out, pin_out}), 32'(e));
  endtask : pin_chk

  task automatic arr(input logic [6:0] v);
    @(posedge clock_in);
    array <= v;
  endtask : arr

  // one pulse on the left or right synchronous clock
  task automatic tick(input bit right);
    @(posedge clock_in);
    if (right) sync_clock_right <= 1'b1;
    else sync_clock_left <= 1'b1;
    repeat (2) @(posedge clock_in);
    sync_clock_right <= 1'b0;
    sync_clock_left <= 1'b0;
  endtask : tick

  // erased register values and unmapped places
  task automatic t_regs;
    rchk(8'h00, 32'h0000FFFF, `RESP_OKAY);
    rchk(8'h24, 32'h0000FFFF, `RESP_OKAY);
    rchk(`OFS_CONFIG, 32'h000003FF, `RESP_OKAY);
    rchk(`OFS_SPLIT, 32'h000000FF, `RESP_OKAY);
    rchk(8'h34, 32'h0, `RESP_SLVERR);
    wr(8'h34, 32'h1, `RESP_SLVERR);
    pin_chk(2'b01);
  endtask : t_regs

  // erased cell: combinatorial, active low, term literals
  task automatic t_comb;
    pt(9, 32'h0);
    pt(0, 32'h1);
    arr(7'h01);
    pin_chk(2'b10);
    arr(7'h00);
    pin_chk(2'b11);
    arr(7'h01);
    pt(0, 32'h3);
    pin_chk(2'b11);
    pt(0, 32'h0);
    pin_chk(2'b10);
  endtask : t_comb

  // register types, clock halves, clear and inversion
  task automatic t_seq;
    cfg(32'h1E0);
    tick(0);
    pin_chk(2'b11);
    pt(0, 32'hFFFF);
    tick(1);
    pin_chk(2'b11);
    tick(0);
    pin_chk(2'b10);
    pt(7, 32'h0);
    tick(0);
    pin_chk(2'b11);
    pt(8, 32'h0);
    pin_chk(2'b10);
    pt(8, 32'hFFFF);
    cfg(32'h1E2);
    tick(0);
    pin_chk(2'b11);
    tick(0);
    pin_chk(2'b10);
    cfg(32'h1E4);
    wr(`OFS_SPLIT, 32'h7F, `RESP_OKAY);
    tick(0);
    pin_chk(2'b10);
    pt(0, 32'h0);
    tick(0);
    pin_chk(2'b11);
    pt(7, 32'hFFFF);
    cfg(32'h1E5);
    tick(0);
    pin_chk(2'b10);
    cfg(32'h1E4);
    tick(0);
    pin_chk(2'b11);
    cfg(32'h1E7);
    tick(0);
    pin_chk(2'b10);
    cfg(32'h1E6);
    tick(0);
    pin_chk(2'b11);
  endtask : t_seq

  // mode 1: always driven, term clocks the register
  task automatic t_mode1;
    cfg(32'h0E0);
    pt(0, 32'hFFFF);
    pt(9, 32'h4);
    arr(7'h02);
    pin_chk(2'b10);
    arr(7'h00);
    pt(0, 32'h0);
    pin_chk(2'b10);
    arr(7'h02);
    pin_chk(2'b11);
  endtask : t_mode1

  // pin as dedicated input, then standby control
  task automatic t_input;
    cfg(32'h1CE);
    pt(0, 32'h4000);
    pt(9, 32'hFFFF);
    @(posedge clock_in);
    drive_val <= 1'b1;
    st_chk(32'h5, 32'h1);
    @(posedge clock_in);
    drive_val <= 1'b0;
    st_chk(32'h5, 32'h0);
    cfg(32'h3CE);
    repeat (15) @(posedge clock_in);
    st_chk(32'h8, 32'h8);
    arr(7'h01);
    settle();
    st_chk(32'h18, 32'h0);
    cfg(32'h1CE);
    repeat (15) @(posedge clock_in);
    st_chk(32'h8, 32'h0);
    // sum fed back holds itself once set
    cfg(32'h1BE);
    st_chk(32'h1, 32'h0);
    pt(1, 32'h1);
    arr(7'h00);
    settle();
    st_chk(32'h1, 32'h1);
  endtask : t_input

  initial begin
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_comb();
    t_seq();
    t_mode1();
    t_input();
    complete_run();
  end
endmodule : pld_macrocell_config_tb
